//--- rtl/complementary_waveform_unit.sv
// complementary waveform unit with dead band and an apb register slave
//
// Notes on behaviour
// [R01] two drives, primary and complementary, come from one selected source
// [R02] one control bit picks pclk or the 16 MHz fast oscillator for counting
// [R03] a three-bit field picks comparator or one of three pwm channels
// [R04] on enable both drives start cleared before any edge is handled
// [R05] each pin has an enable; clear means the unit leaves the pin alone
// [R06] with the unit disabled, pin enables and levels do nothing
// [R07] each output has a polarity bit; set is active high, clear active low
// [R08] override levels go to the pins without polarity inversion
// [R09] two independent six-bit counters, one per input edge direction
// [R10] dead band counts clock periods from zero up to the programmed value
// [R11] rising edge: complementary off now, primary on after rise count
// [R12] rise dead band is programmable as a count of block clock periods
// [R13] falling edge: primary off now, complementary on after fall count
// [R14] fall dead band is programmed independently of the rise value
// [R15] a count of zero adds no delay
// [R16] input reverting before the count ends gives no output pulse
// [R17] realised dead band may vary by at most one block clock period
// [R18] select codes 000 comparator, 001 to 011 pwm channels, rest reserved
// [R19] selected input is synchronised; each edge restarts its counter at zero
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module complementary_waveform_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cwu_pkg::ADDR_W-1:0] paddr,
    input wire logic [cwu_pkg::DATA_W-1:0] pwdata,
    output logic [cwu_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_sync_out,
    input wire logic pwm_channel_one_out,
    input wire logic pwm_channel_two_out,
    input wire logic pwm_channel_three_out,
    input wire logic internal_fast_oscillator,
    output logic primary_drive_out,
    output logic primary_drive_oe,
    output logic complementary_drive_out,
    output logic complementary_drive_oe
);
    import cwu_pkg::*;

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        reg_mapped = (a == UNIT_CONTROL_0_OFS) || (a == UNIT_CONTROL_1_OFS) ||
                     (a == RISE_DEADBAND_OFS) || (a == FALL_DEADBAND_OFS) ||
                     (a == OVERRIDE_CTRL_OFS) || (a == UNIT_STATUS_OFS);
    endfunction

    // register file
    logic [7:0] ctrl0_r, ctrl0_nxt;
    logic [SEL_W-1:0] src_sel_r, src_sel_nxt;
    logic [DB_W-1:0] rise_db_r, rise_db_nxt;
    logic [DB_W-1:0] fall_db_r, fall_db_nxt;
    logic [2:0] ovr_r, ovr_nxt;
    logic [DATA_W-1:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [DATA_W-1:0] status_word;
    logic setup_phase;
    logic write_hit;

    logic drive_a_r, drive_a_nxt;
    logic drive_b_r, drive_b_nxt;
    logic src_s;
    logic rise_busy;
    logic fall_busy;

    assign setup_phase = psel && !penable;
    // writes land on the access edge only, when the slave answers ready
    assign write_hit = psel && penable && pready_r && pwrite && !pslverr_r;

    always_comb begin
        status_word = '0;
        status_word[ST_PRIM_BIT] = drive_a_r;
        status_word[ST_COMP_BIT] = drive_b_r;
        status_word[ST_SRC_BIT] = src_s;
        status_word[ST_RISE_BUSY_BIT] = rise_busy;
        status_word[ST_FALL_BUSY_BIT] = fall_busy;
    end

    always_comb begin
        ctrl0_nxt = ctrl0_r;
        src_sel_nxt = src_sel_r;
        rise_db_nxt = rise_db_r;
        fall_db_nxt = fall_db_r;
        ovr_nxt = ovr_r;
        prdata_nxt = prdata_r;
        // one wait-free access: ready follows the setup cycle
        pready_nxt = setup_phase;
        pslverr_nxt = setup_phase && !reg_mapped(paddr);
        if (setup_phase && !pwrite) begin
            unique case (paddr)
                UNIT_CONTROL_0_OFS: prdata_nxt = {24'h000000, ctrl0_r & 8'hF9};
                UNIT_CONTROL_1_OFS: prdata_nxt = {29'h00000000, src_sel_r};
                RISE_DEADBAND_OFS: prdata_nxt = {26'h0000000, rise_db_r};
                FALL_DEADBAND_OFS: prdata_nxt = {26'h0000000, fall_db_r};
                OVERRIDE_CTRL_OFS: prdata_nxt = {29'h00000000, ovr_r};
                UNIT_STATUS_OFS: prdata_nxt = status_word;
                default: prdata_nxt = '0;
            endcase
        end
        if (write_hit) begin
            unique case (paddr)
                UNIT_CONTROL_0_OFS: ctrl0_nxt = pwdata[7:0] & 8'hF9;
                UNIT_CONTROL_1_OFS: src_sel_nxt = pwdata[SEL_W-1:0]; // [R03]
                RISE_DEADBAND_OFS: rise_db_nxt = pwdata[DB_W-1:0]; // [R12]
                FALL_DEADBAND_OFS: fall_db_nxt = pwdata[DB_W-1:0]; // [R14]
                OVERRIDE_CTRL_OFS: ovr_nxt = pwdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_r <= CTRL0_RESET;
            src_sel_r <= SEL_RESET;
            rise_db_r <= DB_RESET;
            fall_db_r <= DB_RESET;
            ovr_r <= OVR_RESET;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl0_r <= ctrl0_nxt;
            src_sel_r <= src_sel_nxt;
            rise_db_r <= rise_db_nxt;
            fall_db_r <= fall_db_nxt;
            ovr_r <= ovr_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    logic unit_en;
    assign unit_en = ctrl0_r[UNIT_ENABLE_BIT];

    // source selection and synchronisers
    logic src_raw;
    logic osc_s;
    logic [1:0] sync_q;

    always_comb begin
        unique case (src_sel_r) // [R18]
            SRC_COMPARATOR: src_raw = comparator_sync_out;
            SRC_PWM_ONE: src_raw = pwm_channel_one_out;
            SRC_PWM_TWO: src_raw = pwm_channel_two_out;
            SRC_PWM_THREE: src_raw = pwm_channel_three_out;
            default: src_raw = 1'b0;
        endcase
    end

    // source edges may be asynchronous; syncing costs up to one period of jitter [R17] [R19]
    level_sync #(.WIDTH(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({internal_fast_oscillator, src_raw}),
        .sync_out(sync_q)
    );
    assign src_s = sync_q[0];
    assign osc_s = sync_q[1];

    // edge and tick detection
    logic src_prev_r, src_prev_nxt;
    logic osc_prev_r, osc_prev_nxt;
    logic en_prev_r, en_prev_nxt;
    logic rise_edge, fall_edge, en_rise, tick;

    always_comb begin
        src_prev_nxt = src_s;
        osc_prev_nxt = osc_s;
        en_prev_nxt = unit_en;
        rise_edge = unit_en && src_s && !src_prev_r;
        fall_edge = unit_en && !src_s && src_prev_r;
        en_rise = unit_en && !en_prev_r;
        // sampling the 16 MHz oscillator at 40 MHz keeps every edge visible [R02]
        tick = ctrl0_r[CLK_SEL_BIT] ? (osc_s && !osc_prev_r) : 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_r <= 1'b0;
            osc_prev_r <= 1'b0;
            en_prev_r <= 1'b0;
        end else begin
            src_prev_r <= src_prev_nxt;
            osc_prev_r <= osc_prev_nxt;
            en_prev_r <= en_prev_nxt;
        end
    end

    // dead-band counters
    logic rise_done, fall_done;
    logic rise_start, fall_start;

    assign rise_start = rise_edge && !en_rise;
    assign fall_start = fall_edge && !en_rise;

    // the opposite edge aborts a pending count [R09] [R16]
    deadband_counter u_rise_db (
        .pclk(pclk),
        .presetn(presetn),
        .start(rise_start),
        .abort(fall_edge || !unit_en),
        .tick(tick),
        .limit(rise_db_r),
        .done(rise_done),
        .busy(rise_busy)
    );

    deadband_counter u_fall_db (
        .pclk(pclk),
        .presetn(presetn),
        .start(fall_start),
        .abort(rise_edge || !unit_en),
        .tick(tick),
        .limit(fall_db_r),
        .done(fall_done),
        .busy(fall_busy)
    );

    // complementary drive state, both drives from the one synced source [R01]
    always_comb begin
        drive_a_nxt = drive_a_r;
        drive_b_nxt = drive_b_r;
        if (!unit_en || en_rise) begin
            drive_a_nxt = 1'b0; // [R04]
            drive_b_nxt = 1'b0;
        end else begin
            if (rise_start) begin
                drive_b_nxt = 1'b0; // [R11]
            end
            if (rise_done) begin
                drive_a_nxt = 1'b1; // [R11]
            end
            if (fall_start) begin
                drive_a_nxt = 1'b0; // [R13]
            end
            if (fall_done) begin
                drive_b_nxt = 1'b1; // [R13]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_a_r <= 1'b0;
            drive_b_r <= 1'b0;
        end else begin
            drive_a_r <= drive_a_nxt;
            drive_b_r <= drive_b_nxt;
        end
    end

    // pin stage
    logic pa_out_r, pa_out_nxt, pa_oe_r, pa_oe_nxt;
    logic pb_out_r, pb_out_nxt, pb_oe_r, pb_oe_nxt;

    always_comb begin
        // a pin with its enable clear is released and idles low [R05] [R06]
        pa_oe_nxt = unit_en && ctrl0_r[PRIM_OE_BIT];
        pb_oe_nxt = unit_en && ctrl0_r[COMP_OE_BIT];
        pa_out_nxt = 1'b0;
        pb_out_nxt = 1'b0;
        if (ovr_r[OVR_EN_BIT]) begin
            pa_out_nxt = pa_oe_nxt && ovr_r[OVR_PRIM_BIT]; // [R08]
            pb_out_nxt = pb_oe_nxt && ovr_r[OVR_COMP_BIT]; // [R08]
        end else begin
            pa_out_nxt = pa_oe_nxt && (drive_a_r ~^ ctrl0_r[PRIM_POL_BIT]); // [R07]
            pb_out_nxt = pb_oe_nxt && (drive_b_r ~^ ctrl0_r[COMP_POL_BIT]); // [R07]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_out_r <= 1'b0;
            pa_oe_r <= 1'b0;
            pb_out_r <= 1'b0;
            pb_oe_r <= 1'b0;
        end else begin
            pa_out_r <= pa_out_nxt;
            pa_oe_r <= pa_oe_nxt;
            pb_out_r <= pb_out_nxt;
            pb_oe_r <= pb_oe_nxt;
        end
    end

    assign primary_drive_out = pa_out_r;
    assign primary_drive_oe = pa_oe_r;
    assign complementary_drive_out = pb_out_r;
    assign complementary_drive_oe = pb_oe_r;

    // checks
    no_overlap_a: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
        !(drive_a_r && drive_b_r))
        else $error("both drives on together");

    disabled_pins_a: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
        !unit_en |=> !primary_drive_oe && !complementary_drive_oe && !primary_drive_out)
        else $error("pins driven while unit disabled");

    enable_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
        en_rise |=> !drive_a_r && !drive_b_r)
        else $error("drives not cleared on enable");

    rise_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        rise_start && (rise_db_r != '0) |=> !drive_b_r && !drive_a_r)
        else $error("rising edge did not turn complementary off");

    fall_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        fall_start && (fall_db_r != '0) |=> !drive_a_r && !drive_b_r)
        else $error("falling edge did not turn primary off");

    zero_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        rise_start && (rise_db_r == '0) |=> drive_a_r)
        else $error("zero dead band delayed primary");

    rise_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        rise_start && !ctrl0_r[CLK_SEL_BIT] && (rise_db_r == 6'h04) && unit_en
        ##1 (src_s && unit_en)[*4] |=> drive_a_r && !$past(drive_a_r))
        else $error("rise dead band length wrong");

    polarity_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
        unit_en && ctrl0_r[PRIM_OE_BIT] && !ovr_r[OVR_EN_BIT]
        |=> primary_drive_out == ($past(drive_a_r) ~^ $past(ctrl0_r[PRIM_POL_BIT])))
        else $error("primary polarity wrong");

    override_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
        unit_en && ctrl0_r[COMP_OE_BIT] && ovr_r[OVR_EN_BIT]
        |=> complementary_drive_out == $past(ovr_r[OVR_COMP_BIT]))
        else $error("override level altered");

    reserved_src_a: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        (src_sel_r > SRC_PWM_THREE) |-> !src_raw)
        else $error("reserved source code passed a signal");
endmodule // complementary_waveform_unit
`default_nettype wire

//--- rtl/cwu_pkg.sv
// constants shared by the complementary waveform unit files
package cwu_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DB_W = 6;
    localparam int SEL_W = 3;

    localparam real SYS_CLK_MHZ = 40.0;
    localparam real FAST_OSC_MHZ = 16.0;

    // register byte offsets
    localparam logic [7:0] UNIT_CONTROL_0_OFS = 8'h00;
    localparam logic [7:0] UNIT_CONTROL_1_OFS = 8'h04;
    localparam logic [7:0] RISE_DEADBAND_OFS = 8'h08;
    localparam logic [7:0] FALL_DEADBAND_OFS = 8'h0C;
    localparam logic [7:0] OVERRIDE_CTRL_OFS = 8'h10;
    localparam logic [7:0] UNIT_STATUS_OFS = 8'h14;

    // unit_control_0 fields
    localparam int UNIT_ENABLE_BIT = 7;
    localparam int COMP_OE_BIT = 6;
    localparam int PRIM_OE_BIT = 5;
    localparam int COMP_POL_BIT = 4;
    localparam int PRIM_POL_BIT = 3;
    localparam int CLK_SEL_BIT = 0;

    // override_ctrl fields
    localparam int OVR_EN_BIT = 0;
    localparam int OVR_PRIM_BIT = 1;
    localparam int OVR_COMP_BIT = 2;

    // unit_status fields
    localparam int ST_PRIM_BIT = 0;
    localparam int ST_COMP_BIT = 1;
    localparam int ST_SRC_BIT = 2;
    localparam int ST_RISE_BUSY_BIT = 3;
    localparam int ST_FALL_BUSY_BIT = 4;

    // reset values
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
    localparam logic [DB_W-1:0] DB_RESET = 6'h00;
    localparam logic [2:0] OVR_RESET = 3'h0;

    // source select codes; 100..111 are reserved and select a low level
    localparam logic [SEL_W-1:0] SRC_COMPARATOR = 3'h0;
    localparam logic [SEL_W-1:0] SRC_PWM_ONE = 3'h1;
    localparam logic [SEL_W-1:0] SRC_PWM_TWO = 3'h2;
    localparam logic [SEL_W-1:0] SRC_PWM_THREE = 3'h3;

    localparam int SYNC_STAGES = 2;
endpackage : cwu_pkg

//--- rtl/deadband_counter.sv
// one dead-band counter: counts ticks from zero up to the programmed limit
`timescale 1ns/1ps
`default_nettype none
module deadband_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    input wire logic tick,
    input wire logic [cwu_pkg::DB_W-1:0] limit,
    output logic done,
    output logic busy
);
    import cwu_pkg::*;

    logic [DB_W-1:0] count_r;
    logic [DB_W-1:0] count_nxt;
    logic busy_r;
    logic busy_nxt;

    always_comb begin
        count_nxt = count_r;
        busy_nxt = busy_r;
        done = 1'b0;
        if (abort) begin
            // input went back before the count finished: nothing fires [R16]
            busy_nxt = 1'b0;
            count_nxt = '0;
        end else if (start) begin
            count_nxt = '0; // [R19]
            if (limit == '0) begin
                done = 1'b1; // [R15]
                busy_nxt = 1'b0;
            end else begin
                busy_nxt = 1'b1;
            end
        end else if (busy_r && tick) begin
            count_nxt = DB_W'(count_r + 6'h01); // [R10]
            if (DB_W'(count_r + 6'h01) == limit) begin
                done = 1'b1;
                busy_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
            busy_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign busy = busy_r;

    start_arms_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        start && !abort && (limit != '0) |=> busy_r && (count_r == '0))
        else $error("counter did not arm from zero on start");
endmodule // deadband_counter
`default_nettype wire

//--- rtl/level_sync.sv
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            stage_r <= '0;
        end else begin
            meta_r <= async_in;
            stage_r <= meta_r;
        end
    end

    assign sync_out = stage_r;
endmodule // level_sync
`default_nettype wire

//--- verification/gate_driver_model.sv
// behavioural pair of external gate drivers hanging on the two drive pins
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
    input wire logic pclk,
    input wire logic clear,
    input wire logic primary_drive_out,
    input wire logic primary_drive_oe,
    input wire logic complementary_drive_out,
    input wire logic complementary_drive_oe,
    output logic high_gate,
    output logic low_gate,
    output logic shoot_through
);
    logic shoot_nxt;
    // a released pin is held off by the driver input pull-down, never left floating
    assign high_gate = primary_drive_oe ? primary_drive_out : 1'b0;
    assign low_gate = complementary_drive_oe ? complementary_drive_out : 1'b0;
    // sticky flag; only meaningful with both outputs active high
    always_comb begin
        shoot_nxt = shoot_through | (high_gate & low_gate);
        if (clear) begin
            shoot_nxt = 1'b0;
        end
    end
    always_ff @(posedge pclk) begin
        shoot_through <= shoot_nxt;
    end
endmodule // gate_driver_model
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the complementary waveform unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cwu_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc, clear, errv, seen;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdv;
    logic primary_drive_out, primary_drive_oe, complementary_drive_out, complementary_drive_oe;
    logic high_gate, low_gate, shoot_through;
    logic [3:0] src;
    int fails, n_tests, cyc, t0, d, k;

    complementary_waveform_unit complementary_waveform_unit_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .comparator_sync_out(src[0]), .pwm_channel_one_out(src[1]),
        .pwm_channel_two_out(src[2]), .pwm_channel_three_out(src[3]),
        .internal_fast_oscillator(osc),
        .primary_drive_out, .primary_drive_oe, .complementary_drive_out, .complementary_drive_oe
    );
    gate_driver_model gate_driver_model_inst (
        .pclk, .clear, .primary_drive_out, .primary_drive_oe, .complementary_drive_out,
        .complementary_drive_oe, .high_gate, .low_gate, .shoot_through
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // free-running 16 MHz oscillator, offset so that no edge meets a pclk edge
    initial begin
        osc = 1'b0;
        #5;
        forever #31.25 osc = ~osc;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
    end

    task finish_test;
        $display("mismatches %0d, comparisons %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // delays from a source change, in pclk cycles, within a window
    task chk_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            fails++;
            $display("ERROR at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count is assumed; only the watchdog ends a missing answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask

    task set_src(input logic [3:0] v);
        @(posedge pclk);
        src <= v;
        t0 = cyc + 1;
    endtask

    // waits for a pin level; d is the count of edges since the source change
    task wait_pin(input logic which, input logic v);
        k = 0;
        @(negedge pclk);
        while ((which ? complementary_drive_out : primary_drive_out) !== v && k < 200) begin
            @(negedge pclk);
            k++;
        end
        d = cyc - t0;
    endtask

    initial begin
        // span is some forty times the expected length of the run
        #(25 * 20000);
        fails++;
        finish_test;
    end

    initial begin
        fails = 0;
        n_tests = 0;
        cyc = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src = 4'h0;
        clear = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({primary_drive_out, primary_drive_oe, complementary_drive_out, complementary_drive_oe}), 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 32'h0);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, errv}, 32'h1);
        chk(rdv, 32'h0);
        wr(UNIT_STATUS_OFS, 32'hFFFFFFFF);
        rd(UNIT_STATUS_OFS, 32'h0);
        wr(UNIT_CONTROL_0_OFS, 32'hFFFFFFFF);
        rd(UNIT_CONTROL_0_OFS, 32'hF9);
        wr(RISE_DEADBAND_OFS, 32'hFFFFFFFF);
        wr(FALL_DEADBAND_OFS, 32'h15);
        rd(RISE_DEADBAND_OFS, 32'h3F);
        rd(FALL_DEADBAND_OFS, 32'h15);
        wr(UNIT_CONTROL_1_OFS, 32'hFFFFFFFF);
        rd(UNIT_CONTROL_1_OFS, 32'h7);
        wr(UNIT_CONTROL_0_OFS, 32'hF8);
        // codes 000 to 011 must follow exactly their own source; reserved codes must stay low
        for (int i = 0; i < 8; i++) begin
            wr(UNIT_CONTROL_1_OFS, 32'(i));
            set_src(i < 4 ? 4'(1 << i) : 4'hF);
            repeat (6) @(posedge pclk);
            apb(1'b0, UNIT_STATUS_OFS, 32'h0);
            chk(32'(rdv[ST_SRC_BIT]), 32'(i < 4));
            set_src(i < 4 ? ~4'(1 << i) : 4'h0);
            repeat (6) @(posedge pclk);
            apb(1'b0, UNIT_STATUS_OFS, 32'h0);
            chk(32'(rdv[ST_SRC_BIT]), 32'h0);
        end
        wr(UNIT_CONTROL_0_OFS, 32'h0);
        wr(RISE_DEADBAND_OFS, 32'h4);
        wr(FALL_DEADBAND_OFS, 32'h2);
        wr(UNIT_CONTROL_1_OFS, 32'(SRC_PWM_ONE));
        set_src(4'h0);
        wr(UNIT_CONTROL_0_OFS, 32'hF8);
        clear <= 1'b0;
        apb(1'b0, UNIT_STATUS_OFS, 32'h0);
        chk(rdv & 32'h3, 32'h0);
        chk(32'({primary_drive_out, complementary_drive_out}), 32'h0);
        set_src(4'h2);
        // complementary is still cleared from the enable; no fall has come yet
        wait_pin(1'b1, 1'b0);
        chk_rng(d, 0, 0);
        wait_pin(1'b0, 1'b1);
        chk_rng(d, 8, 10);
        set_src(4'h0);
        wait_pin(1'b0, 1'b0);
        chk_rng(d, 4, 6);
        wait_pin(1'b1, 1'b1);
        chk_rng(d, 6, 8);
        wr(RISE_DEADBAND_OFS, 32'h0);
        set_src(4'h2);
        wait_pin(1'b1, 1'b0);
        chk_rng(d, 4, 6);
        wait_pin(1'b0, 1'b1);
        chk_rng(d, 4, 6);
        chk({31'h0, shoot_through}, 32'h0);
        wr(RISE_DEADBAND_OFS, 32'hA);
        set_src(4'h0);
        repeat (12) @(posedge pclk);
        set_src(4'h2);
        repeat (3) @(posedge pclk);
        set_src(4'h0);
        seen = 1'b0;
        repeat (30) begin
            @(negedge pclk);
            if (primary_drive_out === 1'b1) begin
                seen = 1'b1;
            end
        end
        chk({31'h0, seen}, 32'h0);
        // a second rise must restart the count, not resume it
        set_src(4'h2);
        repeat (5) @(posedge pclk);
        set_src(4'h0);
        repeat (1) @(posedge pclk);
        set_src(4'h2);
        wait_pin(1'b0, 1'b1);
        chk_rng(d, 14, 16);
        set_src(4'h0);
        repeat (20) @(posedge pclk);
        clear <= 1'b1;
        wr(UNIT_CONTROL_0_OFS, 32'hE0);
        // pins are registered one cycle behind the control bits
        repeat (2) @(negedge pclk);
        chk(32'({primary_drive_out, complementary_drive_out}), 32'h2);
        wr(OVERRIDE_CTRL_OFS, 32'h5);
        repeat (2) @(negedge pclk);
        chk(32'({primary_drive_out, complementary_drive_out}), 32'h1);
        wr(OVERRIDE_CTRL_OFS, 32'h0);
        wr(UNIT_CONTROL_0_OFS, 32'hD8);
        repeat (2) @(negedge pclk);
        chk(32'({primary_drive_oe, complementary_drive_oe}), 32'h1);
        wr(OVERRIDE_CTRL_OFS, 32'h7);
        wr(UNIT_CONTROL_0_OFS, 32'h78);
        repeat (2) @(negedge pclk);
        chk(32'({primary_drive_out, primary_drive_oe, complementary_drive_out, complementary_drive_oe}), 32'h0);
        wr(OVERRIDE_CTRL_OFS, 32'h0);
        // eight oscillator periods land far from the eight pclk cycles of the other clock
        wr(RISE_DEADBAND_OFS, 32'h8);
        wr(UNIT_CONTROL_0_OFS, 32'hF9);
        set_src(4'h2);
        wait_pin(1'b0, 1'b1);
        chk_rng(d, 21, 32);
        finish_test;
    end
endmodule // testbench
`default_nettype wire
